// File: common/mspt_consts.svh
// Register offsets, field positions and reset values of the pulse timer.
// Included by the package and by every design file that decodes registers.
`ifndef MSPT_CONSTS_SVH
`define MSPT_CONSTS_SVH

`define MSPT_CW            16
`define MSPT_AW            8
`define MSPT_OFF_CTRL      8'h00
`define MSPT_OFF_PRESC     8'h04
`define MSPT_OFF_MMODE     8'h08
`define MSPT_OFF_SMODE     8'h0C
`define MSPT_OFF_MDATA     8'h10
`define MSPT_OFF_SDATA     8'h14
`define MSPT_OFF_MCNT      8'h18
`define MSPT_OFF_SCNT      8'h1C
`define MSPT_OFF_START     8'h20
`define MSPT_OFF_STOP      8'h24
`define MSPT_OFF_ENSTAT    8'h28
`define MSPT_OFF_OLEV      8'h2C
`define MSPT_OFF_OEN       8'h30
`define MSPT_OFF_OPOL      8'h34
`define MSPT_OFF_OMODE     8'h38

`define MSPT_CTRL_POWER    0
`define MSPT_MODE_CKS_LSB  0
`define MSPT_MODE_ONESHOT  2
`define MSPT_MODE_EDGE_LSB 4
`define MSPT_MASTER_BIT    0
`define MSPT_SLAVE_BIT     1
`define MSPT_EDGE_FALL     2'h0
`define MSPT_EDGE_RISE     2'h1
`define MSPT_EDGE_BOTH     2'h2
`define MSPT_PRESC_SELW    4
`define MSPT_NUM_CLK       4

`define MSPT_RST_BYTE      8'h00
`define MSPT_RST_HALF      16'h0000
`define MSPT_CNT_ZERO      16'h0000

`endif

// File: common/mspt_pkg.sv
// Types shared by the pulse timer modules.
// Relies on mspt_consts.svh for widths.
`include "mspt_consts.svh"

package mspt_pkg;

  typedef enum logic [1:0] {
    MSPT_CH_IDLE = 2'b00,
    MSPT_CH_WAIT = 2'b01,
    MSPT_CH_LOAD = 2'b10,
    MSPT_CH_RUN  = 2'b11
  } mspt_ch_state_e;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [`MSPT_AW-1:0] paddr;
    logic [31:0]         pwdata;
  } mspt_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mspt_apb_rsp_s;

  typedef struct packed {
    logic                start;
    logic                stop;
    logic                trig;
    logic                tick;
    logic                reload;
    logic                irq_on_load;
    logic                clr;
    logic [`MSPT_CW-1:0] data;
  } mspt_ch_ctl_s;

endpackage : mspt_pkg

// File: logic/mspt_prescaler.sv
// Count clock prescaler: four tick streams, each dividing ref_clk_i by 2^sel.
// Assumes run_i comes from a register on the same clock.
`timescale 1ns/100ps
`default_nettype none

module mspt_prescaler #(
  parameter int NCLK = 4,
  parameter int SELW = 4,
  parameter int DW   = 16
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 run_i,
  input  wire logic [NCLK*SELW-1:0] sel_i,
  output logic      [NCLK-1:0]      tick_o
);
  import mspt_pkg::*;

  if ((1 << SELW) > DW) begin : g_bad
    $error("prescaler counter too narrow for select width");
  end

  typedef struct packed {
    logic [DW-1:0]   cnt;
    logic [NCLK-1:0] tick;
  } mspt_psc_s;

  mspt_psc_s       q;
  mspt_psc_s       d;
  logic [NCLK-1:0] hit_w;

  for (genvar g = 0; g < NCLK; g++) begin : g_clk
    logic [DW-1:0] mask_w;
    assign mask_w   = ~({DW{1'b1}} << sel_i[g*SELW +: SELW]);
    assign hit_w[g] = (q.cnt & mask_w) == mask_w;
  end

  // Stopped unit gets no count clock at all
  always_comb begin
    d      = q;
    d.cnt  = run_i ? q.cnt + 1'b1 : '0;
    d.tick = run_i ? hit_w : '0;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  fast_tick_a : assert property (
    run_i && sel_i[SELW-1:0] == '0 |=> tick_o[0])
    else $error("undivided count clock missed a tick");

endmodule : mspt_prescaler

`default_nettype wire

// File: logic/mspt_channel.sv
// One timer channel: sixteen-bit down counter with load, reload and stop.
// Assumes start, stop, trig and tick are single-cycle pulses on ref_clk_i.
`timescale 1ns/100ps
`default_nettype none
`include "mspt_consts.svh"

module mspt_channel #(
  parameter int CW = 16
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_i,
  input  wire mspt_pkg::mspt_ch_ctl_s ctl_i,
  output var mspt_pkg::mspt_ch_state_e state_o,
  output logic [CW-1:0]               cnt_o,
  output logic                        irq_o
);
  import mspt_pkg::*;

  if (CW != `MSPT_CW) begin : g_bad
    $error("channel width must match the data field");
  end

  typedef struct packed {
    mspt_ch_state_e st;
    logic [CW-1:0]  cnt;
    logic           irq;
  } mspt_ch_s;

  mspt_ch_s q;
  mspt_ch_s d;

  always_comb begin
    d     = q;
    d.irq = 1'b0;
    if (ctl_i.clr) begin
      d.st  = MSPT_CH_IDLE;
      d.cnt = '0;
    end else if (ctl_i.stop) begin
      d.st = MSPT_CH_IDLE;
    end else if (ctl_i.trig && (ctl_i.start || q.st != MSPT_CH_IDLE)) begin
      if (ctl_i.tick) begin
        // A trigger on a count tick loads at once, so no tick is lost
        d.cnt = ctl_i.data;
        d.st  = MSPT_CH_RUN;
        d.irq = ctl_i.irq_on_load;
      end else begin
        d.st = MSPT_CH_LOAD;
        if (q.st == MSPT_CH_IDLE) begin
          d.cnt = '0;
        end
      end
    end else if (ctl_i.start && q.st == MSPT_CH_IDLE) begin
      d.st  = MSPT_CH_WAIT;
      d.cnt = '0;
    end else if (ctl_i.tick) begin
      case (q.st)
        MSPT_CH_LOAD: begin
          d.cnt = ctl_i.data;
          d.st  = MSPT_CH_RUN;
          d.irq = ctl_i.irq_on_load;
        end
        MSPT_CH_RUN: begin
          if (ctl_i.reload && q.cnt == '0) begin
            d.irq = 1'b1;
            d.cnt = ctl_i.data;
          end else if (!ctl_i.reload && q.cnt <= CW'(1)) begin
            // One-count mode stops on the tick that reaches zero
            d.irq = 1'b1;
            d.cnt = '0;
            d.st  = MSPT_CH_WAIT;
          end else begin
            d.cnt = q.cnt - 1'b1;
          end
        end
        default: begin
          d.st = q.st;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign state_o = q.st;
  assign cnt_o   = q.cnt;
  assign irq_o   = q.irq;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  load_irq_a : assert property (
    q.st == MSPT_CH_LOAD && ctl_i.tick && ctl_i.irq_on_load && !ctl_i.clr
    && !ctl_i.stop && !ctl_i.trig |=> irq_o && cnt_o == $past(ctl_i.data))
    else $error("load did not raise the done pulse with data");

  reload_zero_a : assert property (
    q.st == MSPT_CH_RUN && q.cnt == '0 && ctl_i.tick && ctl_i.reload
    && !ctl_i.clr && !ctl_i.stop && !ctl_i.trig
    |=> irq_o && state_o == MSPT_CH_RUN && cnt_o == $past(ctl_i.data))
    else $error("interval reload at zero failed");

  one_count_a : assert property (
    q.st == MSPT_CH_RUN && q.cnt <= CW'(1) && ctl_i.tick && !ctl_i.reload
    && !ctl_i.clr && !ctl_i.stop && !ctl_i.trig
    |=> irq_o && state_o == MSPT_CH_WAIT && cnt_o == '0)
    else $error("one-count stop at zero failed");

  stop_freeze_a : assert property (
    ctl_i.stop && !ctl_i.clr |=> state_o == MSPT_CH_IDLE && $stable(cnt_o))
    else $error("stop did not freeze the counter");

endmodule : mspt_channel

`default_nettype wire

// File: logic/mspt_top.sv
// Master/slave pulse timer pair with its APB register file.
// Assumes an APB master on ref_clk_i and an asynchronous trigger pin.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "mspt_consts.svh"

// Function
// - Output bit sets slave pin level
// - Enable bit lets counting drive output
// - Power off: no clock, writes ignored
// - Power off clears registers and output
// - Prescaler select sets four count clocks
// - Start bits set enable flags, self-clear
// - PWM master pulses done on start
// - PWM master reloads at zero, continues
// - Slave loads on master done, stops
// - Output active one tick after done
// - Counters readable; output bits stay writable
// - Stop bits freeze counters, hold output
// - Disabled output shows written level
// - One-shot master counts once per trigger
// - One-shot trigger: pin edge or software
// - One-shot slave counts once, pulses done
// - Delay data plus two, width data
// - Polarity bit inverts active level
// - Slave zero or large gives constant
module mspt_top (
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  input  wire mspt_pkg::mspt_apb_req_s apb_req_i,
  output var  mspt_pkg::mspt_apb_rsp_s apb_rsp_o,
  input  wire logic                    master_trigger_input_i,
  output logic                         slave_output_pin_o,
  output logic                         slave_output_pin_oe_n_o,
  output logic                         master_done_irq_o,
  output logic                         slave_done_irq_o
);
  import mspt_pkg::*;

  localparam int MB = `MSPT_MASTER_BIT;
  localparam int SB = `MSPT_SLAVE_BIT;

  typedef struct packed {
    logic                power;
    logic [15:0]         presc;
    logic [7:0]          mmode;
    logic [7:0]          smode;
    logic [`MSPT_CW-1:0] mdata;
    logic [`MSPT_CW-1:0] sdata;
    logic [7:0]          olev;
    logic [7:0]          oen;
    logic [7:0]          opol;
    logic [7:0]          omode;
    logic [1:0]          start;
    logic [1:0]          stop;
    logic                trg_s1;
    logic                trg_s2;
    logic                trg_prev;
    logic                s_act;
    logic                oe_n;
    mspt_apb_rsp_s       rsp;
  } mspt_top_s;

  mspt_top_s                       q;
  mspt_top_s                       d;
  logic [`MSPT_NUM_CLK-1:0]        ticks_w;
  mspt_ch_ctl_s                    m_ctl_w;
  mspt_ch_ctl_s                    s_ctl_w;
  mspt_ch_state_e                  m_st_w;
  mspt_ch_state_e                  s_st_w;
  logic [`MSPT_CW-1:0]             m_cnt_w;
  logic [`MSPT_CW-1:0]             s_cnt_w;
  logic                            m_irq_w;
  logic                            s_irq_w;
  logic                            setup_w;
  logic                            wr_w;
  logic                            wr_ok_w;
  logic                            oneshot_w;
  logic                            rise_w;
  logic                            fall_w;
  logic                            edge_w;
  logic                            s_active_w;
  logic [1:0]                      ensta_w;

  assign setup_w = apb_req_i.psel && !apb_req_i.penable;
  assign wr_w    = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite
                   && q.rsp.pready;
  // Only the power bit is reachable while the unit is unpowered
  assign wr_ok_w = wr_w && (q.power
                   || apb_req_i.paddr == `MSPT_OFF_CTRL);

  assign oneshot_w = q.mmode[`MSPT_MODE_ONESHOT];
  assign rise_w    = q.trg_s2 && !q.trg_prev;
  assign fall_w    = !q.trg_s2 && q.trg_prev;

  always_comb begin
    case (q.mmode[`MSPT_MODE_EDGE_LSB +: 2])
      `MSPT_EDGE_FALL: edge_w = fall_w;
      `MSPT_EDGE_RISE: edge_w = rise_w;
      `MSPT_EDGE_BOTH: edge_w = rise_w || fall_w;
      default:         edge_w = 1'b0;
    endcase
  end

  mspt_prescaler #(
    .NCLK (`MSPT_NUM_CLK),
    .SELW (`MSPT_PRESC_SELW),
    .DW   (16)
  ) u_presc (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .run_i     (q.power),
    .sel_i     (q.presc),
    .tick_o    (ticks_w)
  );

  always_comb begin
    m_ctl_w.start       = q.start[MB];
    m_ctl_w.stop        = q.stop[MB];
    // In one-shot mode a start only arms the master; a pin edge or a
    // further start while armed launches the delay count
    m_ctl_w.trig        = (q.start[MB]
                           && !(oneshot_w && m_st_w == MSPT_CH_IDLE))
                          || (oneshot_w && edge_w);
    m_ctl_w.tick        = ticks_w[q.mmode[`MSPT_MODE_CKS_LSB +: 2]];
    m_ctl_w.reload      = !oneshot_w;
    m_ctl_w.irq_on_load = !oneshot_w;
    m_ctl_w.clr         = !q.power;
    m_ctl_w.data        = q.mdata;
    s_ctl_w.start       = q.start[SB];
    s_ctl_w.stop        = q.stop[SB];
    s_ctl_w.trig        = m_irq_w;
    s_ctl_w.tick        = ticks_w[q.smode[`MSPT_MODE_CKS_LSB +: 2]];
    s_ctl_w.reload      = 1'b0;
    s_ctl_w.irq_on_load = 1'b0;
    s_ctl_w.clr         = !q.power;
    s_ctl_w.data        = q.sdata;
  end

  mspt_channel #(
    .CW (`MSPT_CW)
  ) u_master (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .ctl_i     (m_ctl_w),
    .state_o   (m_st_w),
    .cnt_o     (m_cnt_w),
    .irq_o     (m_irq_w)
  );

  mspt_channel #(
    .CW (`MSPT_CW)
  ) u_slave (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .ctl_i     (s_ctl_w),
    .state_o   (s_st_w),
    .cnt_o     (s_cnt_w),
    .irq_o     (s_irq_w)
  );

  // Keeping the old count during reload avoids a one-tick dip at full duty
  assign s_active_w = (s_st_w == MSPT_CH_RUN || s_st_w == MSPT_CH_LOAD)
                      && s_cnt_w != `MSPT_CNT_ZERO;
  assign ensta_w    = {s_st_w != MSPT_CH_IDLE, m_st_w != MSPT_CH_IDLE};

  always_comb begin
    d          = q;
    d.start    = 2'b00;
    d.stop     = 2'b00;
    d.trg_s1   = master_trigger_input_i;
    d.trg_s2   = q.trg_s1;
    d.trg_prev = q.trg_s2;
    d.s_act    = s_active_w;
    d.rsp      = '0;
    d.rsp.pready = setup_w;
    if (setup_w && !apb_req_i.pwrite) begin
      case (apb_req_i.paddr)
        `MSPT_OFF_CTRL:   d.rsp.prdata = 32'(q.power);
        `MSPT_OFF_PRESC:  d.rsp.prdata = 32'(q.presc);
        `MSPT_OFF_MMODE:  d.rsp.prdata = 32'(q.mmode);
        `MSPT_OFF_SMODE:  d.rsp.prdata = 32'(q.smode);
        `MSPT_OFF_MDATA:  d.rsp.prdata = 32'(q.mdata);
        `MSPT_OFF_SDATA:  d.rsp.prdata = 32'(q.sdata);
        `MSPT_OFF_MCNT:   d.rsp.prdata = 32'(m_cnt_w);
        `MSPT_OFF_SCNT:   d.rsp.prdata = 32'(s_cnt_w);
        `MSPT_OFF_START:  d.rsp.prdata = 32'h0000_0000;
        `MSPT_OFF_STOP:   d.rsp.prdata = 32'h0000_0000;
        `MSPT_OFF_ENSTAT: d.rsp.prdata = 32'(ensta_w);
        `MSPT_OFF_OLEV:   d.rsp.prdata = 32'(q.olev);
        `MSPT_OFF_OEN:    d.rsp.prdata = 32'(q.oen);
        `MSPT_OFF_OPOL:   d.rsp.prdata = 32'(q.opol);
        `MSPT_OFF_OMODE:  d.rsp.prdata = 32'(q.omode);
        default:          d.rsp.pslverr = 1'b1;
      endcase
    end else if (setup_w) begin
      case (apb_req_i.paddr)
        `MSPT_OFF_CTRL, `MSPT_OFF_PRESC, `MSPT_OFF_MMODE, `MSPT_OFF_SMODE,
        `MSPT_OFF_MDATA, `MSPT_OFF_SDATA, `MSPT_OFF_MCNT, `MSPT_OFF_SCNT,
        `MSPT_OFF_START, `MSPT_OFF_STOP, `MSPT_OFF_ENSTAT, `MSPT_OFF_OLEV,
        `MSPT_OFF_OEN, `MSPT_OFF_OPOL, `MSPT_OFF_OMODE: d.rsp.pslverr = 1'b0;
        default: d.rsp.pslverr = 1'b1;
      endcase
    end
    if (wr_ok_w) begin
      case (apb_req_i.paddr)
        `MSPT_OFF_CTRL:  d.power = apb_req_i.pwdata[`MSPT_CTRL_POWER];
        `MSPT_OFF_PRESC: d.presc = apb_req_i.pwdata[15:0];
        `MSPT_OFF_MMODE: d.mmode = apb_req_i.pwdata[7:0];
        `MSPT_OFF_SMODE: d.smode = apb_req_i.pwdata[7:0];
        `MSPT_OFF_MDATA: d.mdata = apb_req_i.pwdata[`MSPT_CW-1:0];
        `MSPT_OFF_SDATA: d.sdata = apb_req_i.pwdata[`MSPT_CW-1:0];
        `MSPT_OFF_START: d.start = apb_req_i.pwdata[1:0];
        `MSPT_OFF_STOP:  d.stop  = apb_req_i.pwdata[1:0];
        `MSPT_OFF_OLEV:  d.olev  = apb_req_i.pwdata[7:0];
        `MSPT_OFF_OEN:   d.oen   = apb_req_i.pwdata[7:0];
        `MSPT_OFF_OPOL:  d.opol  = apb_req_i.pwdata[7:0];
        `MSPT_OFF_OMODE: d.omode = apb_req_i.pwdata[7:0];
        default: begin
          d.power = q.power;
        end
      endcase
    end
    // Counting wins over a software write to the output bit in one cycle
    if (q.oen[SB] && q.omode[SB] && s_st_w != MSPT_CH_IDLE
        && s_active_w != q.s_act) begin
      d.olev[SB] = s_active_w ^ q.opol[SB];
    end
    if (!d.power) begin
      d.presc = `MSPT_RST_HALF;
      d.mmode = `MSPT_RST_BYTE;
      d.smode = `MSPT_RST_BYTE;
      d.mdata = `MSPT_RST_HALF;
      d.sdata = `MSPT_RST_HALF;
      d.olev  = `MSPT_RST_BYTE;
      d.oen   = `MSPT_RST_BYTE;
      d.opol  = `MSPT_RST_BYTE;
      d.omode = `MSPT_RST_BYTE;
      d.start = 2'b00;
      d.stop  = 2'b00;
    end
    // Pin falls back to port mode whenever the unit is unpowered
    d.oe_n = !d.power;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q      <= '0;
      q.oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign apb_rsp_o               = q.rsp;
  assign slave_output_pin_o      = q.olev[SB];
  assign slave_output_pin_oe_n_o = q.oe_n;
  assign master_done_irq_o       = m_irq_w;
  assign slave_done_irq_o        = s_irq_w;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sw_level_a : assert property (
    wr_ok_w && apb_req_i.paddr == `MSPT_OFF_OLEV && !q.oen[SB]
    |=> slave_output_pin_o == $past(apb_req_i.pwdata[SB]))
    else $error("written output bit did not reach the pin");

  count_blocked_a : assert property (
    q.power && !q.oen[SB] && !wr_w |=> $stable(slave_output_pin_o))
    else $error("pin moved while counting had no control");

  power_gate_a : assert property (
    !q.power && wr_w && apb_req_i.paddr == `MSPT_OFF_MDATA
    |=> q.mdata == `MSPT_RST_HALF)
    else $error("write accepted while unpowered");

  power_clear_a : assert property (
    q.power && wr_w && apb_req_i.paddr == `MSPT_OFF_CTRL
    && !apb_req_i.pwdata[`MSPT_CTRL_POWER]
    |=> !slave_output_pin_o && slave_output_pin_oe_n_o
        ##1 m_st_w == MSPT_CH_IDLE && s_st_w == MSPT_CH_IDLE)
    else $error("power off did not clear the unit");

  start_pair_a : assert property (
    q.power && wr_ok_w && apb_req_i.paddr == `MSPT_OFF_START
    && apb_req_i.pwdata[1:0] == 2'b11 && q.stop == 2'b00
    |=> q.start == 2'b11 ##1 q.start == 2'b00 && ensta_w == 2'b11)
    else $error("start bits did not enable both channels");

  stop_hold_a : assert property (
    q.power && s_st_w == MSPT_CH_IDLE && !wr_w
    |=> $stable(slave_output_pin_o))
    else $error("stopped slave changed its output");

endmodule : mspt_top

`default_nettype wire

// File: test/mspt_load_model.sv
// External load on the slave output pin: measures each active pulse.
// Assumes a pull-down on the line while the timer does not drive it.
`timescale 1ns/100ps
`default_nettype none

module mspt_load_model (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        pin_i,
  input  wire logic        oe_n_i,
  input  wire logic        pol_i,
  output logic             line_o,
  output logic             rep_o,
  output logic [15:0]      width_o,
  output logic [15:0]      period_o
);
  logic        act;
  logic        act_q;
  logic [15:0] hi_q;
  logic [15:0] per_q;

  // Released line falls to the pull-down, never keeps the last level
  assign line_o = oe_n_i ? 1'b0 : pin_i;
  assign act    = line_o ^ pol_i;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      act_q    <= 1'b0;
      rep_o    <= 1'b0;
      hi_q     <= 16'h0000;
      per_q    <= 16'h0000;
      width_o  <= 16'h0000;
      period_o <= 16'h0000;
    end else begin
      act_q <= act;
      rep_o <= act_q & ~act;
      hi_q  <= act ? hi_q + 16'h0001 : 16'h0000;
      per_q <= (act & ~act_q) ? 16'h0001 : per_q + 16'h0001;
      if (act_q & ~act) width_o <= hi_q;
      if (act & ~act_q) period_o <= per_q;
    end
  end
endmodule : mspt_load_model

`default_nettype wire

// File: test/tb.sv
// Self-checking bench of the pulse timer pair: APB master, load, monitor.
// Assumes count clock 0 for both channels; APB waits for pready.
`timescale 1ns/100ps
`default_nettype none
`include "mspt_consts.svh"

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); \
  end end

module tb;
  import mspt_pkg::*;
  logic          ref_clk_i;
  logic          reset_i;
  mspt_apb_req_s req;
  mspt_apb_rsp_s rsp;
  logic          trig;
  logic          pin;
  logic          oe_n;
  logic          mirq_p;
  logic          sirq_p;
  logic          pol;
  logic          line;
  logic          rep;
  logic [15:0]   wid;
  logic [15:0]   per;
  logic [15:0]   md;
  logic [15:0]   sd;
  logic [33:0]   re;
  logic [31:0]   pe;
  logic [33:0]   rd_q[$];
  logic [31:0]   pw_q[$];
  int            fail_count;
  int            tests_run;
  int            mirq;
  int            sirq;
  int            n;

  mspt_top dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .apb_req_i(req), .apb_rsp_o(rsp), .master_trigger_input_i(trig),
    .slave_output_pin_o(pin), .slave_output_pin_oe_n_o(oe_n),
    .master_done_irq_o(mirq_p), .slave_done_irq_o(sirq_p));

  mspt_load_model load_u (.clk_i(ref_clk_i), .reset_i(reset_i),
    .pin_i(pin), .oe_n_i(oe_n), .pol_i(pol), .line_o(line), .rep_o(rep),
    .width_o(wid), .period_o(per));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task complete_run;
    $display("mismatches %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (rsp.pready !== 1'b1);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Bit 33 asks for a data compare, bit 32 is the expected error flag
  task rd(input logic [7:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task wait_line(input logic lvl);
    n = 0;
    while (line !== lvl) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask : wait_line

  always @(posedge ref_clk_i) begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite
        && rd_q.size() > 0) begin
      re = rd_q.pop_front();
      `CHK(rsp.pslverr, re[32])
      if (re[33]) `CHK(rsp.prdata, re[31:0])
    end
    if (rep === 1'b1 && pw_q.size() > 0) begin
      pe = pw_q.pop_front();
      `CHK({per, wid}, pe)
    end
    if (mirq_p === 1'b1) mirq++;
    if (sirq_p === 1'b1) sirq++;
  end

  initial begin
    repeat (40000) @(posedge ref_clk_i);
    fail_count++;
    complete_run();
  end

  initial begin
    req = '0;
    trig = 1'b0;
    pol = 1'b0;
    reset_i = 1'b1;
    void'($urandom(32'h28073646));
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    wr(`MSPT_OFF_MDATA, 32'h5);
    wr(`MSPT_OFF_CTRL, 32'h1);
    rd(`MSPT_OFF_MDATA, {2'b10, 32'h0});
    rd(8'hF0, {2'b01, 32'h0});
    wr(`MSPT_OFF_OMODE, 32'h2);
    for (int p = 0; p < 2; p++) begin
      md = 16'h4 + 16'($urandom % 12);
      sd = 16'h1 + 16'($urandom % md);
      pol = p[0];
      wr(`MSPT_OFF_PRESC, p);
      wr(`MSPT_OFF_OPOL, p << 1);
      wr(`MSPT_OFF_OLEV, p << 1);
      wr(`MSPT_OFF_MDATA, {16'h0, md});
      wr(`MSPT_OFF_SDATA, {16'h0, sd});
      wr(`MSPT_OFF_OEN, 32'h2);
      wr(`MSPT_OFF_START, 32'h3);
      rd(`MSPT_OFF_ENSTAT, {2'b10, 32'h3});
      rd(`MSPT_OFF_START, {2'b10, 32'h0});
      // First pulse has no reference rise, so it is only waited for
      while (rep !== 1'b1) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      repeat (2) pw_q.push_back({16'((md + 16'h1) << p), 16'(sd << p)});
      while (pw_q.size() > 0) @(posedge ref_clk_i);
      rd(`MSPT_OFF_MDATA, {2'b10, 16'h0, md});
      wr(`MSPT_OFF_STOP, 32'h3);
      rd(`MSPT_OFF_ENSTAT, {2'b10, 32'h0});
      wr(`MSPT_OFF_OEN, 32'h0);
      wr(`MSPT_OFF_OLEV, 32'h2);
      repeat (2) @(posedge ref_clk_i);
      `CHK(pin, 1'b1)
      wr(`MSPT_OFF_OLEV, 32'h0);
      repeat (2) @(posedge ref_clk_i);
      `CHK(pin, 1'b0)
    end
    pol = 1'b0;
    md = 16'h3 + 16'($urandom % 10);
    sd = 16'h1 + 16'($urandom % 10);
    wr(`MSPT_OFF_PRESC, 32'h0);
    wr(`MSPT_OFF_OPOL, 32'h0);
    wr(`MSPT_OFF_OEN, 32'h2);
    wr(`MSPT_OFF_MMODE, 32'h14);
    wr(`MSPT_OFF_MDATA, {16'h0, md});
    wr(`MSPT_OFF_SDATA, {16'h0, sd});
    wr(`MSPT_OFF_START, 32'h3);
    repeat (4) @(posedge ref_clk_i);
    mirq = 0;
    sirq = 0;
    trig <= 1'b1;
    wait_line(1'b1);
    `CHK(n - 1, 32'(md) + 5)
    wait_line(1'b0);
    repeat (3) @(posedge ref_clk_i);
    `CHK(wid, sd)
    trig <= 1'b0;
    repeat (64) @(posedge ref_clk_i);
    `CHK(mirq, 1)
    `CHK(sirq, 1)
    rd(`MSPT_OFF_MCNT, {2'b10, 32'h0});
    rd(`MSPT_OFF_SCNT, {2'b10, 32'h0});
    wr(`MSPT_OFF_CTRL, 32'h0);
    rd(`MSPT_OFF_OEN, {2'b10, 32'h0});
    rd(`MSPT_OFF_MMODE, {2'b10, 32'h0});
    repeat (2) @(posedge ref_clk_i);
    `CHK(oe_n, 1'b1)
    `CHK(pin, 1'b0)
    complete_run();
  end
endmodule : tb

`default_nettype wire
